// ==== design/pba_pkg.sv ====
// Shared constants, carrier types and arithmetic for the reference timing block.
package pba_pkg;

  //----------------------------------------------------------------------------
  // Packet layout
  //----------------------------------------------------------------------------
  localparam logic [7:0] SYNC_BYTE         = 8'h47;
  localparam logic [7:0] POS_SYNC          = 8'h00;
  localparam logic [7:0] POS_PID_HI        = 8'h01;
  localparam logic [7:0] POS_PID_LO        = 8'h02;
  localparam logic [7:0] POS_CTRL          = 8'h03;
  localparam logic [7:0] POS_AF_LEN        = 8'h04;
  localparam logic [7:0] POS_AF_FLAGS      = 8'h05;
  localparam logic [7:0] POS_PCR_FIRST     = 8'h06;
  localparam logic [7:0] POS_PCR_BASE_LAST = 8'h0a;
  localparam logic [7:0] POS_PCR_EXT_LO    = 8'h0b;
  localparam logic [7:0] POS_PKT_LAST      = 8'hbb;
  localparam int unsigned PID_W            = 13;
  localparam int unsigned BIT_AF_PRESENT   = 5;
  localparam int unsigned BIT_DISCONT      = 7;
  localparam int unsigned BIT_PCR_FLAG     = 4;

  //----------------------------------------------------------------------------
  // Clock reference format and arithmetic widths
  //----------------------------------------------------------------------------
  localparam int unsigned BASE_W   = 33;
  localparam int unsigned EXT_W    = 9;
  localparam int unsigned EXT_MOD  = 300;
  localparam int unsigned PCR_W    = BASE_W + EXT_W;
  localparam int unsigned FRAC_W   = 16;
  localparam int unsigned AW       = PCR_W + FRAC_W;
  localparam int unsigned IDX_W    = 32;
  localparam int unsigned RATE_W   = 32;
  localparam int unsigned NOMINAL_BYTE_TICKS = 8;
  localparam logic [EXT_W-1:0]  EXT_LAST  = EXT_W'(EXT_MOD - 1);
  localparam logic [PCR_W-1:0]  PCR_WRAP  = PCR_W'(EXT_MOD) << BASE_W;
  localparam logic [AW-1:0]     WRAP_FX   = {PCR_WRAP, {FRAC_W{1'b0}}};
  localparam logic [RATE_W-1:0] RATE_RESET = RATE_W'(NOMINAL_BYTE_TICKS) << FRAC_W;

  //----------------------------------------------------------------------------
  // Carrier types
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic [BASE_W-1:0] base;
    logic [EXT_W-1:0]  ext;
  } pba_pcr_t;

  typedef struct packed {
    logic [7:0]       data;
    logic             is_ref;
    logic [PCR_W-1:0] arrival;
    logic [IDX_W-1:0] index;
  } pba_stamp_t;

  //----------------------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------------------
  // Full reference value in system clock cycles: coarse times 300 plus fine.
  function automatic logic [PCR_W-1:0] pcr_value(input pba_pcr_t p);
    return PCR_W'(p.base) * PCR_W'(EXT_MOD) + PCR_W'(p.ext);
  endfunction

  // Fixed-point time sum that wraps where the reference value wraps.
  function automatic logic [AW-1:0] fx_add(input logic [AW-1:0] a, input logic [AW-1:0] b);
    logic [AW:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    if (sum >= {1'b0, WRAP_FX}) begin
      sum = sum - {1'b0, WRAP_FX};
    end
    return sum[AW-1:0];
  endfunction

endpackage

// ==== design/pba_fifo.sv ====
// Shift-register FIFO whose head word and flags come straight from flip-flops.
module pba_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [CW-1:0]    count_q;
  logic [CW-1:0]    count_d;
  logic [CW-1:0]    wr_idx;
  logic             push;
  logic             pop;

  if (DEPTH < 2 || WIDTH < 1) begin
    $error("pba_fifo needs DEPTH of at least 2 and WIDTH of at least 1.");
  end

  // A pop and a push in one cycle are both honoured, but a full FIFO drops in_ready and takes no push while it pops.
  assign push    = in_valid && in_ready;
  assign pop     = out_valid && out_ready;
  assign count_d = count_q + CW'(push) - CW'(pop);
  assign wr_idx  = count_q - CW'(pop);
  assign out_data = mem_q[0];

  // Occupancy and the registered flags derived from the next occupancy.
  always_ff @(posedge mclk) begin
    if (rst) begin
      count_q   <= '0;
      out_valid <= 1'b0;
      in_ready  <= 1'b1;
    end else begin
      count_q   <= count_d;
      out_valid <= count_d != '0;
      in_ready  <= count_d != CW'(DEPTH);
    end
  end

  // Each slot shifts toward the head on a pop and takes the new word when it is the tail.
  for (genvar i = 0; i < DEPTH; i++) begin
    always_ff @(posedge mclk) begin
      if (push && wr_idx == CW'(i)) begin
        mem_q[i] <= in_data;
      end else if (pop) begin
        if (i < DEPTH - 1) begin
          mem_q[i] <= mem_q[(i + 1) % DEPTH];
        end
      end
    end
  end

endmodule

// ==== design/pba_divider.sv ====
// Sequential restoring divider that yields one quotient bit per clock.
module pba_divider #(
  parameter int unsigned NUM_W = 58,
  parameter int unsigned DEN_W = 32
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic [NUM_W-1:0] num,
  input  wire logic [DEN_W-1:0] den,
  output logic                  busy,
  output logic                  done,
  output logic [NUM_W-1:0]      quot
);
  typedef enum logic {DIV_IDLE, DIV_RUN} pba_div_state_t;
  localparam int unsigned CW = $clog2(NUM_W + 1);

  pba_div_state_t   state_q;
  logic [CW-1:0]    cnt_q;
  logic [DEN_W:0]   rem_q;
  logic [DEN_W:0]   rem_shift;
  logic [DEN_W-1:0] den_q;
  logic [NUM_W-1:0] work_q;
  logic             fits;

  if (NUM_W < 2 || DEN_W < 1) begin
    $error("pba_divider needs NUM_W of at least 2 and DEN_W of at least 1.");
  end

  // The dividend shifts out of the top of work_q while quotient bits shift in below.
  assign rem_shift = {rem_q[DEN_W-1:0], work_q[NUM_W-1]};
  assign fits      = rem_shift >= {1'b0, den_q};
  assign busy      = state_q == DIV_RUN;
  assign quot      = work_q;

  // Sequencing: one pass of NUM_W cycles per start; starts while running are ignored.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= DIV_IDLE;
      cnt_q   <= '0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_q)
        DIV_IDLE: begin
          if (start) begin
            state_q <= DIV_RUN;
            cnt_q   <= CW'(NUM_W);
          end
        end
        DIV_RUN: begin
          cnt_q <= cnt_q - CW'(1);
          if (cnt_q == CW'(1)) begin
            state_q <= DIV_IDLE;
            done    <= 1'b1;
          end
        end
        default: state_q <= DIV_IDLE;
      endcase
    end
  end

  // Datapath.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rem_q  <= '0;
      work_q <= '0;
      den_q  <= '0;
    end else if (state_q == DIV_IDLE && start) begin
      rem_q  <= '0;
      work_q <= num;
      den_q  <= den;
    end else if (state_q == DIV_RUN) begin
      rem_q  <= fits ? rem_shift - {1'b0, den_q} : rem_shift;
      work_q <= {work_q[NUM_W-2:0], fits};
    end
  end

endmodule

// ==== design/pba_timing_top.sv ====
// Reference extraction, transport rate measurement and per-byte arrival stamping for one program.
//------------------------------------------------------------------------------
// What this block does
// - Coarse reference counts the system clock divided by 300 and wraps at two^33.
// - Reference is 33-bit coarse plus 9-bit fine; value is coarse*300 plus fine.
// - A reference stamps the byte holding the last bit of its coarse field.
// - Rate is bytes between reference bytes over the difference of reference values.
// - Each byte time is the earlier reference plus its offset divided by the rate.
// - After a timebase discontinuity, keep timing with the old timebase's last rate.
// - Rates count system clock cycles; nominal rate moves one byte per 8 cycles.
// - Only one selected program is decoded and all timing uses its time base.
// - References come only from adaptation fields of the selected reference identifier.
// - Stream bytes are numbered consecutively from zero for byte counting and stamping.
// - The 13-bit packet identifier sits in the 4-byte prefix and selects packets.
//------------------------------------------------------------------------------
module pba_timing_top #(
  parameter int unsigned FIFO_DEPTH = 4
) (
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic [pba_pkg::PID_W-1:0]    sel_pid,
  input  wire logic                         in_valid,
  input  wire logic [7:0]                   in_data,
  output logic                              in_ready,
  output logic                              out_valid,
  output pba_pkg::pba_stamp_t               out_stamp,
  input  wire logic                         out_ready,
  output logic [pba_pkg::RATE_W-1:0]        rate_ticks,
  output logic                              ref_strobe,
  output logic                              ref_discont,
  output pba_pkg::pba_pcr_t                 ref_pcr,
  output pba_pkg::pba_pcr_t                 ref_local
);
  localparam int unsigned AW     = pba_pkg::AW;
  localparam int unsigned PCR_W  = pba_pkg::PCR_W;
  localparam int unsigned BASE_W = pba_pkg::BASE_W;
  localparam int unsigned IDX_W  = pba_pkg::IDX_W;
  localparam int unsigned RATE_W = pba_pkg::RATE_W;
  localparam int unsigned FRAC_W = pba_pkg::FRAC_W;

  if (FIFO_DEPTH < 2) begin
    $error("pba_timing_top needs FIFO_DEPTH of at least 2.");
  end

  //----------------------------------------------------------------------------
  // Declarations
  //----------------------------------------------------------------------------
  logic                        accept;
  logic                        ref_byte;
  logic                        pcr_done;
  pba_pkg::pba_stamp_t         stamp;
  logic [7:0]                  pos_q;
  logic [pba_pkg::PID_W-1:0]   pid_q;
  logic                        af_present_q;
  logic [7:0]                  af_len_q;
  logic                        pcr_sel_q;
  logic                        disc_q;
  logic [BASE_W-1:0]           pcr_base_q;
  logic                        ext_hi_q;
  logic [IDX_W-1:0]            byte_idx_q;
  logic [IDX_W-1:0]            ref_idx_q;
  logic [IDX_W-1:0]            prev_idx_q;
  logic [PCR_W-1:0]            prev_pcr_q;
  logic                        have_prev_q;
  pba_pkg::pba_pcr_t           stc_q;
  logic [AW-1:0]               arr_q;
  logic [RATE_W-1:0]           rate_q;
  pba_pkg::pba_pcr_t           pcr_now;
  logic [PCR_W-1:0]            pcr_ticks;
  logic [PCR_W-1:0]            pcr_delta;
  logic [IDX_W-1:0]            idx_delta;
  logic                        div_start;
  logic                        div_busy;
  logic                        div_done;
  logic [AW-1:0]               div_quot;

  //----------------------------------------------------------------------------
  // Byte acceptance and reference decode
  //----------------------------------------------------------------------------
  // A byte is taken only when the FIFO can hold its stamp, so back-pressure stalls the source.
  assign accept   = in_valid && in_ready;
  assign ref_byte = accept && pcr_sel_q && pos_q == pba_pkg::POS_PCR_BASE_LAST;
  assign pcr_done = accept && pcr_sel_q && pos_q == pba_pkg::POS_PCR_EXT_LO;

  // The fine part's low byte arrives live on the bus in the completing cycle.
  assign pcr_now   = {pcr_base_q, ext_hi_q, in_data};
  assign pcr_ticks = pba_pkg::pcr_value(pcr_now);

  // Reference difference taken modulo the full reference wrap.
  assign pcr_delta = (pcr_ticks >= prev_pcr_q) ? pcr_ticks - prev_pcr_q
                                               : pcr_ticks + (pba_pkg::PCR_WRAP - prev_pcr_q);
  assign idx_delta = ref_idx_q - prev_idx_q;

  // A new rate is measured only inside one timebase; a discontinuity keeps the old rate.
  assign div_start = pcr_done && have_prev_q && !disc_q && !div_busy && idx_delta != '0;

  //----------------------------------------------------------------------------
  // Packet position tracking
  //----------------------------------------------------------------------------
  // Position stays at zero until a sync byte shows up, which also recovers from lost alignment.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pos_q <= pba_pkg::POS_SYNC;
    end else if (accept) begin
      if (pos_q == pba_pkg::POS_SYNC && in_data != pba_pkg::SYNC_BYTE) begin
        pos_q <= pba_pkg::POS_SYNC;
      end else if (pos_q == pba_pkg::POS_PKT_LAST) begin
        pos_q <= pba_pkg::POS_SYNC;
      end else begin
        pos_q <= pos_q + 8'h01;
      end
    end
  end

  // Every byte of the stream gets the next index, counting from zero.
  always_ff @(posedge mclk) begin
    if (rst) begin
      byte_idx_q <= '0;
    end else if (accept) begin
      byte_idx_q <= byte_idx_q + IDX_W'(1);
    end
  end

  //----------------------------------------------------------------------------
  // Prefix and adaptation field parsing
  //----------------------------------------------------------------------------
  // Packet identifier and adaptation field control from the 4-byte prefix.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pid_q        <= '0;
      af_present_q <= 1'b0;
      af_len_q     <= 8'h00;
    end else if (accept) begin
      case (pos_q)
        pba_pkg::POS_PID_HI: pid_q[pba_pkg::PID_W-1:8] <= in_data[pba_pkg::PID_W-9:0];
        pba_pkg::POS_PID_LO: pid_q[7:0] <= in_data;
        pba_pkg::POS_CTRL:   af_present_q <= in_data[pba_pkg::BIT_AF_PRESENT];
        pba_pkg::POS_AF_LEN: af_len_q <= in_data;
        default: begin
        end
      endcase
    end
  end

  // The flag byte decides whether this packet carries a usable reference for our program.
  // Other programs' references are ignored, since their time bases are unrelated to ours.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pcr_sel_q <= 1'b0;
      disc_q    <= 1'b0;
    end else if (accept) begin
      if (pos_q == pba_pkg::POS_AF_FLAGS) begin
        pcr_sel_q <= af_present_q && af_len_q != 8'h00 && in_data[pba_pkg::BIT_PCR_FLAG]
                     && pid_q == sel_pid;
        disc_q    <= af_present_q && af_len_q != 8'h00 && in_data[pba_pkg::BIT_DISCONT];
      end else if (pos_q == pba_pkg::POS_PKT_LAST) begin
        pcr_sel_q <= 1'b0;
      end
    end
  end

  // Coarse field gathers MSB first over five bytes; fine high bit shares the fifth byte.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pcr_base_q <= '0;
      ext_hi_q   <= 1'b0;
    end else if (accept && pcr_sel_q) begin
      if (pos_q >= pba_pkg::POS_PCR_FIRST && pos_q < pba_pkg::POS_PCR_BASE_LAST) begin
        pcr_base_q <= {pcr_base_q[BASE_W-9:0], in_data};
      end else if (pos_q == pba_pkg::POS_PCR_BASE_LAST) begin
        pcr_base_q <= {pcr_base_q[BASE_W-2:0], in_data[7]};
        ext_hi_q   <= in_data[0];
      end
    end
  end

  //----------------------------------------------------------------------------
  // Local system time clock
  //----------------------------------------------------------------------------
  // Fine part counts 0 to 299; the coarse part steps once per fine wrap and wraps by width.
  always_ff @(posedge mclk) begin
    if (rst) begin
      stc_q <= '0;
    end else if (stc_q.ext == pba_pkg::EXT_LAST) begin
      stc_q.ext  <= '0;
      stc_q.base <= stc_q.base + BASE_W'(1);
    end else begin
      stc_q.ext <= stc_q.ext + pba_pkg::EXT_W'(1);
    end
  end

  // The local time is caught on the reference byte so software can compare the two clocks.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ref_local <= '0;
      ref_idx_q <= '0;
    end else if (ref_byte) begin
      ref_local <= stc_q;
      ref_idx_q <= byte_idx_q;
    end
  end

  //----------------------------------------------------------------------------
  // Reference bookkeeping and rate measurement
  //----------------------------------------------------------------------------
  // Each completed reference becomes the anchor of the next interval, also across a new timebase.
  always_ff @(posedge mclk) begin
    if (rst) begin
      prev_pcr_q  <= '0;
      prev_idx_q  <= '0;
      have_prev_q <= 1'b0;
      ref_strobe  <= 1'b0;
      ref_discont <= 1'b0;
      ref_pcr     <= '0;
    end else begin
      ref_strobe <= pcr_done;
      if (pcr_done) begin
        prev_pcr_q  <= pcr_ticks;
        prev_idx_q  <= ref_idx_q;
        have_prev_q <= 1'b1;
        ref_discont <= disc_q;
        ref_pcr     <= pcr_now;
      end
    end
  end

  // Ticks per byte in fixed point: the rate inverse, in system clock cycles.
  pba_divider #(
    .NUM_W (AW),
    .DEN_W (IDX_W)
  ) u_divider (
    .mclk  (mclk),
    .rst   (rst),
    .start (div_start),
    .num   ({pcr_delta, {FRAC_W{1'b0}}}),
    .den   (idx_delta),
    .busy  (div_busy),
    .done  (div_done),
    .quot  (div_quot)
  );

  // The measured spacing replaces the old one only when a division finishes; it saturates
  // rather than wrap, because a wrapped spacing would put stamps far in the past.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rate_q <= pba_pkg::RATE_RESET;
    end else if (div_done) begin
      rate_q <= (|div_quot[AW-1:RATE_W]) ? '1 : div_quot[RATE_W-1:0];
    end
  end

  assign rate_ticks = rate_q;

  //----------------------------------------------------------------------------
  // Arrival time interpolation
  //----------------------------------------------------------------------------
  // The accumulator holds the time of the byte now on the input. At the reference's last
  // byte it is re-anchored two byte spacings after the reference value, since the reference
  // byte sits one byte earlier; bytes after a discontinuity keep the held spacing.
  always_ff @(posedge mclk) begin
    if (rst) begin
      arr_q <= '0;
    end else if (pcr_done) begin
      arr_q <= pba_pkg::fx_add({pcr_ticks, {FRAC_W{1'b0}}}, AW'(rate_q) << 1);
    end else if (accept) begin
      arr_q <= pba_pkg::fx_add(arr_q, AW'(rate_q));
    end
  end

  // Stamp for the byte on the input; the FIFO registers it.
  always_comb begin
    stamp.data    = in_data;
    stamp.is_ref  = ref_byte;
    stamp.arrival = arr_q[AW-1:FRAC_W];
    stamp.index   = byte_idx_q;
  end

  //----------------------------------------------------------------------------
  // Output buffer
  //----------------------------------------------------------------------------
  pba_fifo #(
    .WIDTH ($bits(pba_pkg::pba_stamp_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (in_valid),
    .in_data   (stamp),
    .in_ready  (in_ready),
    .out_valid (out_valid),
    .out_data  (out_stamp),
    .out_ready (out_ready)
  );

endmodule

// ==== bench/pba_timing_sva.sv ====
// Port checker for the reference timing block.
module pba_chk #(
  parameter int unsigned FIFO_DEPTH = 4
) (
  input wire logic                         mclk,
  input wire logic                         rst,
  input wire logic                         in_valid,
  input wire logic                         in_ready,
  input wire logic                         out_valid,
  input wire pba_pkg::pba_stamp_t          out_stamp,
  input wire logic                         out_ready,
  input wire logic [pba_pkg::RATE_W-1:0]   rate_ticks,
  input wire logic                         ref_strobe,
  input wire logic                         ref_discont,
  input wire pba_pkg::pba_pcr_t            ref_pcr,
  input wire pba_pkg::pba_pcr_t            ref_local
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]                occ_q;
  logic [7:0]                age_q;
  logic                      seen_q;
  logic [pba_pkg::IDX_W-1:0] idx_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // --------
  // Helpers: buffer fill, cycles since a reference, last index taken.
  // --------
  always_ff @(posedge mclk) begin
    if (rst) begin
      occ_q  <= 4'h0;
      age_q  <= 8'hff;
      seen_q <= 1'b0;
    end else begin
      occ_q <= occ_q + 4'(in_valid && in_ready) - 4'(out_valid && out_ready);
      age_q <= ref_strobe ? 8'h00 : age_q + 8'(age_q != 8'hff);
      if (out_valid && out_ready) begin
        seen_q <= 1'b1;
        idx_q  <= out_stamp.index;
      end
    end
  end
  ready_full_a: assert property (in_ready == (occ_q != 4'(FIFO_DEPTH)))
    else $error("input ready disagrees with buffer fill");
  valid_empty_a: assert property (out_valid == (occ_q != 4'h0))
    else $error("output valid disagrees with buffer fill");
  stamp_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_stamp))
    else $error("stamp changed while stalled");
  index_step_a: assert property (out_valid && out_ready && seen_q |-> out_stamp.index == idx_q + 1)
    else $error("byte index skipped");
  strobe_pulse_a: assert property (ref_strobe |=> !ref_strobe)
    else $error("reference strobe too long");
  pcr_hold_a: assert property ($changed(ref_pcr) && !$past(rst) |-> ref_strobe)
    else $error("reference value moved without strobe");
  rate_time_a: assert property ($changed(rate_ticks) && !$past(rst) |-> age_q inside {[54:62]})
    else $error("rate changed at wrong time");
  discont_rate_a: assert property ($changed(rate_ticks) && !$past(rst) |-> !ref_discont)
    else $error("rate measured across a new timebase");
  fine_range_a: assert property (ref_local.ext < 9'h12c)
    else $error("local fine count out of range");
endmodule

bind pba_timing_top pba_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (.mclk(mclk), .rst(rst), .in_valid(in_valid),
  .in_ready(in_ready), .out_valid(out_valid), .out_stamp(out_stamp), .out_ready(out_ready),
  .rate_ticks(rate_ticks), .ref_strobe(ref_strobe), .ref_discont(ref_discont), .ref_pcr(ref_pcr),
  .ref_local(ref_local));

// ==== bench/pba_src.sv ====
// Stream source model that sends one packet of 188 bytes per request.
module pba_src (
  input wire logic                      mclk,
  input wire logic                      rst,
  input wire logic                      go,
  input wire logic [pba_pkg::PID_W-1:0] pid,
  input wire pba_pkg::pba_pcr_t         val,
  input wire logic                      disc,
  input wire logic                      in_ready,
  output logic                          in_valid,
  output logic [7:0]                    in_data,
  output logic                          busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pos_q;
  // Packet byte at position p; only the prefix, adaptation and reference fields carry meaning.
  function automatic logic [7:0] pkt_byte(input logic [7:0] p);
    case (p)
      8'h01: return 8'(pid[12:8]);
      8'h02: return pid[7:0];
      8'h03: return 8'h30;
      8'h04: return 8'h07;
      8'h05: return {disc, 2'h0, 1'b1, 4'h0};
      8'h06: return val.base[32:25];
      8'h07: return val.base[24:17];
      8'h08: return val.base[16:9];
      8'h09: return val.base[8:1];
      8'h0a: return {val.base[0], 6'h3f, val.ext[8]};
      8'h0b: return val.ext[7:0];
      default: return 8'hff;
    endcase
  endfunction
  // One byte per cycle keeps the rate constant; an idle line flips so no stale byte shows.
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy     <= 1'b0;
      in_valid <= 1'b0;
      in_data  <= 8'h00;
      pos_q    <= 8'h00;
    end else if (go && !busy) begin
      busy     <= 1'b1;
      in_valid <= 1'b1;
      pos_q    <= 8'h00;
      in_data  <= 8'h47;
    end else if (busy && in_ready && pos_q == pba_pkg::POS_PKT_LAST) begin
      busy     <= 1'b0;
      in_valid <= 1'b0;
      in_data  <= ~in_data;
    end else if (busy && in_ready) begin
      pos_q   <= pos_q + 8'h01;
      in_data <= pkt_byte(pos_q + 8'h01);
    end else if (!busy) begin
      in_data <= ~in_data;
    end
  end
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the reference timing block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [12:0] pid; pba_pkg::pba_pcr_t val; logic disc; int n; logic [31:0] rate;} pba_row_t;
  logic mclk, rst, in_valid, in_ready, out_valid, out_ready, ref_strobe, ref_discont, go, busy, disc;
  logic [12:0] pid;
  logic [7:0] in_data;
  logic [31:0] rate_ticks;
  pba_pkg::pba_stamp_t out_stamp;
  pba_pkg::pba_pcr_t ref_pcr, ref_local, val, exp_pcr;
  int err_count, checks, strobes, pops, acc, s0, i;
  // Rows: one packet each; values hold a 10, then 12, cycle spacing over the measured spans.
  pba_row_t rows [5] = '{'{13'h100, 42'h64, 0, 1, 32'h80000}, '{13'h101, 42'ha00, 0, 0, 32'h80000},
    '{13'h100, 42'h1904, 0, 1, 32'ha0000}, '{13'h100, 42'h7d000, 1, 1, 32'ha0000},
    '{13'h100, 42'h7de9c, 0, 1, 32'hc0000}};
  pba_src src_u (.mclk(mclk), .rst(rst), .go(go), .pid(pid), .val(val), .disc(disc), .in_ready(in_ready),
    .in_valid(in_valid), .in_data(in_data), .busy(busy));
  pba_timing_top dut_u (.mclk(mclk), .rst(rst), .sel_pid(13'h100), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .out_valid(out_valid), .out_stamp(out_stamp), .out_ready(out_ready),
    .rate_ticks(rate_ticks), .ref_strobe(ref_strobe), .ref_discont(ref_discont), .ref_pcr(ref_pcr),
    .ref_local(ref_local));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic start(input logic [12:0] p, input pba_pkg::pba_pcr_t v, input logic d);
    @(posedge mclk);
    pid <= p;
    val <= v;
    disc <= d;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 1000 && (busy || go); n++) @(posedge mclk);
    if (busy) begin
      err_count++;
      $display("FAIL %0t source stuck", $time);
      close_out();
    end
  endtask
  // Clock of 25 ns.
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Monitor: counts strobes and taken bytes, checks indices and first arrivals.
  always @(posedge mclk) begin
    if (rst) begin
      strobes = 0;
      pops = 0;
    end else begin
      if (ref_strobe) strobes++;
      if (in_valid && in_ready) acc++;
      if (out_valid && out_ready) begin
        check(64'(out_stamp.index), 64'(pops));
        if (pops < 2) check(64'(out_stamp.arrival), 64'(8 * pops));
        check(64'(out_stamp.is_ref), 64'(i < 5 && out_stamp.index inside {10, 386, 574, 762}));
        if (out_stamp.index == 388) check(64'(out_stamp.arrival), 64'd3876);
        if (out_stamp.index == 576) check(64'(out_stamp.arrival), 64'd300020);
        if (out_stamp.index % 188 == 0) check(64'(out_stamp.data), 64'h47);
        pops++;
      end
    end
  end
  // Main sequence: reset, packet rows, then buffer and reset cases.
  initial begin
    {rst, out_ready, go, disc, pid, val, exp_pcr} = {3'b110, 98'h0};
    repeat (5) @(posedge mclk);
    #1 check(64'({in_ready, out_valid, ref_strobe, rate_ticks}), 64'h4_0008_0000);
    @(posedge mclk) rst <= 1'b0;
    for (i = 0; i < 5; i++) begin
      s0 = strobes;
      start(rows[i].pid, rows[i].val, rows[i].disc);
      wait_idle();
      if (rows[i].n != 0) exp_pcr = rows[i].val;
      check(64'(strobes - s0), 64'(rows[i].n));
      check(64'(ref_pcr), 64'(exp_pcr));
      check(64'(ref_discont), 64'(rows[i].disc));
      check(64'(rate_ticks), 64'(rows[i].rate));
      $display("row %0d done", i);
    end
    out_ready <= 1'b0;
    s0 = acc;
    start(13'h101, 42'h0, 1'b0);
    repeat (12) @(posedge mclk);
    check(64'({acc - s0, in_ready}), 64'({32'd4, 1'b0}));
    out_ready <= 1'b1;
    wait_idle();
    repeat (4) @(posedge mclk);
    check(64'(out_valid), 64'h0);
    $display("buffer test done");
    start(13'h101, 42'h0, 1'b0);
    repeat (30) @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 check(64'({rate_ticks, ref_pcr}), 64'(32'h80000) << 42);
    @(posedge mclk) rst <= 1'b0;
    start(13'h101, 42'h0, 1'b0);
    wait_idle();
    check(64'(pops > 2), 64'h1);
    $display("reset test done");
    close_out();
  end
endmodule
